// ---- rx_status_defs.svh ----
// Purpose: offsets, bit positions, reset values and limits of the
//          receive error, fifo status and collision register group
// Assumes: 6-bit register addresses on the serial register port
// Notes:   definitions only
`ifndef RX_STATUS_DEFS_SVH
`define RX_STATUS_DEFS_SVH

`define ADDR_ERR_WAKE 6'h19
`define ADDR_FIFO_FILL 6'h1a
`define ADDR_FIFO_STAT 6'h1b
`define ADDR_COLLISION 6'h1c

`define BIT_CRC 7
`define BIT_PARITY 6
`define BIT_SOFT_FRAME 5
`define BIT_HARD_FRAME 4
`define BIT_WAKE_TIMER 3
`define BIT_WAKE_AMP 2
`define BIT_WAKE_PHASE 1
`define BIT_WAKE_CAP 0

`define BIT_UNDERFLOW 6
`define BIT_OVERFLOW 5
`define BIT_INCOMPLETE 4
`define POS_LB_COUNT 1
`define BIT_NO_PARITY 0

`define POS_COL_BYTE 4
`define POS_COL_BIT 1
`define BIT_COL_PARITY 0

`define RESET_BYTE 8'h00
`define FIFO_EMPTY 7'h00
`define FIFO_MAX_FILL 7'h60

`endif

// ---- rx_status_pkg.sv ----
// Purpose: shared types of the receive status register group
// Assumes: nothing beyond the defs header
// Notes:   types only, constants live in rx_status_defs.svh
package rx_status_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [5:0] reg_addr_t;
    typedef logic [6:0] fifo_fill_t;
    typedef logic [2:0] bit_count_t;
    typedef logic [3:0] byte_count_t;
endpackage : rx_status_pkg

// ---- collision_tracker.sv ----
// Purpose: holds the collision position of the current receive frame
// Assumes: collision info is valid in the cycle of the collision pulse
// Notes:   only the first collision of a frame can raise a parity error
`timescale 1ns/1ns
`default_nettype none
`include "rx_status_defs.svh"

module collision_tracker (
    input wire logic clock,
    input wire logic nrst,
    input wire logic set_default,
    input wire logic rx_start,
    input wire logic collision,
    input wire logic collision_in_anticoll,
    input wire rx_status_pkg::byte_count_t collision_byte,
    input wire rx_status_pkg::bit_count_t collision_bit,
    input wire logic collision_on_parity,
    output rx_status_pkg::reg_byte_t collision_position,
    output logic parity_collision_error
);
    logic seen_collision;
    wire take = collision && collision_in_anticoll;
    wire rx_status_pkg::reg_byte_t next_collision_position =
        {collision_byte, collision_bit, collision_on_parity};

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            collision_position <= `RESET_BYTE;
            seen_collision <= 1'b0;
            parity_collision_error <= 1'b0;
        end else if (set_default) begin
            collision_position <= `RESET_BYTE;
            seen_collision <= 1'b0;
            parity_collision_error <= 1'b0;
        end else begin
            // longer frames leave the last anticollision result in place
            if (take) begin
                collision_position <= next_collision_position;
            end
            parity_collision_error <= collision && collision_on_parity
                && !seen_collision;
            if (rx_start) begin
                seen_collision <= 1'b0;
            end else if (collision) begin
                seen_collision <= 1'b1;
            end
        end
    end

    property p_col_update;
        @(posedge clock) disable iff (!nrst)
        take && !set_default |=>
            collision_position == $past(next_collision_position);
    endproperty
    a_col_update: assert property (p_col_update)
        else $error("collision position not captured");

    property p_col_hold;
        @(posedge clock) disable iff (!nrst)
        !take && !set_default |=> $stable(collision_position);
    endproperty
    a_col_hold: assert property (p_col_hold)
        else $error("collision position changed outside anticollision");

    property p_par_first;
        @(posedge clock) disable iff (!nrst)
        collision && collision_on_parity && seen_collision |=>
            !parity_collision_error;
    endproperty
    a_par_first: assert property (p_par_first)
        else $error("parity collision error after first collision");

    c_col_capture: cover property (@(posedge clock) disable iff (!nrst)
        take ##1 collision_position[`BIT_COL_PARITY]);
endmodule : collision_tracker
`default_nettype wire

// ---- rx_error_fifo_status_regs.sv ----
// Purpose: error and wake-up flags, fifo status and collision display
//          registers, read by the host over the serial register port
// Assumes: all event inputs are one-cycle pulses synchronous to clock
// Notes:   reads answer one cycle after the strobe
//
// Notes on behaviour
// - intact-data framing error sets bit 5
// - corrupting framing error sets bit 4
// - wake timer timeout sets bit 3 if enabled
// - amplitude delta exceeded sets bit 2
// - phase delta exceeded sets bit 1
// - capacitance delta exceeded sets bit 0
// - power-up and set-default zero all registers
// - main register read clears error flags
// - pending flags show as main bit 0
// - seven-bit unread fifo byte count, 0 to 96
// - underflow sets bit 6, overflow bit 5
// - incomplete last byte: flag and bit count
// - missing last parity flagged, counts as framing error
// - empty fifo zeroes count, incomplete flag and bit count
// - reading fifo status two clears last-byte fields
// - collision reports full bytes before it
// - collision reports bits before it in byte
// - position kept only inside anticollision frame length
// - parity-bit collision flagged, error on first only
`timescale 1ns/1ns
`default_nettype none
`include "rx_status_defs.svh"

module rx_error_fifo_status_regs (
    input wire logic clock,
    input wire logic nrst,
    input wire logic set_default,
    input wire logic rd_strobe,
    input wire rx_status_pkg::reg_addr_t rd_addr,
    output rx_status_pkg::reg_byte_t rd_data,
    output logic rd_valid,
    input wire logic main_irq_read,
    output logic err_pending,
    input wire logic crc_error,
    input wire logic parity_error,
    input wire logic soft_framing_error,
    input wire logic hard_framing_error,
    input wire logic wake_timer_timeout,
    input wire logic wake_timer_irq_every,
    input wire logic amp_wake,
    input wire logic phase_wake,
    input wire logic cap_wake,
    input wire logic rx_start,
    input wire rx_status_pkg::fifo_fill_t fifo_level,
    input wire logic fifo_underflow,
    input wire logic fifo_overflow,
    input wire logic last_byte_done,
    input wire logic last_byte_partial,
    input wire rx_status_pkg::bit_count_t last_byte_bits,
    input wire logic last_byte_no_parity,
    input wire logic collision,
    input wire logic collision_in_anticoll,
    input wire rx_status_pkg::byte_count_t collision_byte,
    input wire rx_status_pkg::bit_count_t collision_bit,
    input wire logic collision_on_parity
);
    rx_status_pkg::reg_byte_t error_wakeup_irq_flags;
    rx_status_pkg::fifo_fill_t fifo_count;
    logic underflow_flag;
    logic overflow_flag;
    logic incomplete_flag;
    rx_status_pkg::bit_count_t last_byte_bit_count;
    logic missing_parity_flag;
    rx_status_pkg::reg_byte_t collision_position;
    logic parity_collision_error;

    // ---------------- collision display ----------------
    collision_tracker tracker (
        .clock(clock),
        .nrst(nrst),
        .set_default(set_default),
        .rx_start(rx_start),
        .collision(collision),
        .collision_in_anticoll(collision_in_anticoll),
        .collision_byte(collision_byte),
        .collision_bit(collision_bit),
        .collision_on_parity(collision_on_parity),
        .collision_position(collision_position),
        .parity_collision_error(parity_collision_error)
    );

    // ---------------- error and wake-up flags ----------------
    wire soft_framing_flag_set = soft_framing_error
        || (last_byte_done && last_byte_no_parity);
    wire wake_timer_flag_set = wake_timer_timeout
        && wake_timer_irq_every;
    wire rx_status_pkg::reg_byte_t flag_set = {
        crc_error,
        parity_error || parity_collision_error,
        soft_framing_flag_set,
        hard_framing_error,
        wake_timer_flag_set,
        amp_wake,
        phase_wake,
        cap_wake
    };
    wire any_flag_set = |flag_set;

    wire rd_err_reg = rd_strobe && rd_addr == `ADDR_ERR_WAKE;
    wire rd_fifo_fill = rd_strobe && rd_addr == `ADDR_FIFO_FILL;
    wire rd_fifo_stat = rd_strobe && rd_addr == `ADDR_FIFO_STAT;
    wire rd_collision = rd_strobe && rd_addr == `ADDR_COLLISION;

    // a set in the clearing cycle survives, so no event is lost
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_flag
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    error_wakeup_irq_flags[i] <= 1'b0;
                end else if (set_default) begin
                    error_wakeup_irq_flags[i] <= 1'b0;
                end else if (flag_set[i]) begin
                    error_wakeup_irq_flags[i] <= 1'b1;
                end else if (main_irq_read) begin
                    error_wakeup_irq_flags[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // main bit 0 stays up until software has looked at the details
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            err_pending <= 1'b0;
        end else if (set_default) begin
            err_pending <= 1'b0;
        end else if (any_flag_set) begin
            err_pending <= 1'b1;
        end else if (rd_err_reg) begin
            err_pending <= 1'b0;
        end
    end

    // ---------------- fifo status ----------------
    wire fifo_empty = fifo_level == `FIFO_EMPTY;
    // levels above the fifo size cannot occur, clamp for safety
    wire rx_status_pkg::fifo_fill_t next_fifo_count =
        (fifo_level > `FIFO_MAX_FILL) ? `FIFO_MAX_FILL : fifo_level;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fifo_count <= `FIFO_EMPTY;
        end else if (set_default) begin
            fifo_count <= `FIFO_EMPTY;
        end else begin
            fifo_count <= next_fifo_count;
        end
    end

    // overflow and underflow stay until a new reception starts
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            underflow_flag <= 1'b0;
            overflow_flag <= 1'b0;
        end else if (set_default) begin
            underflow_flag <= 1'b0;
            overflow_flag <= 1'b0;
        end else begin
            underflow_flag <= fifo_underflow
                || (underflow_flag && !rx_start);
            overflow_flag <= fifo_overflow
                || (overflow_flag && !rx_start);
        end
    end

    // empty wins over a new last byte; a new last byte wins over read
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            incomplete_flag <= 1'b0;
            last_byte_bit_count <= 3'h0;
        end else if (set_default || fifo_empty) begin
            incomplete_flag <= 1'b0;
            last_byte_bit_count <= 3'h0;
        end else if (last_byte_done) begin
            incomplete_flag <= last_byte_partial;
            last_byte_bit_count <= last_byte_partial ? last_byte_bits
                : 3'h0;
        end else if (rd_fifo_stat) begin
            incomplete_flag <= 1'b0;
            last_byte_bit_count <= 3'h0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            missing_parity_flag <= 1'b0;
        end else if (set_default) begin
            missing_parity_flag <= 1'b0;
        end else if (last_byte_done) begin
            missing_parity_flag <= last_byte_no_parity;
        end else if (rd_fifo_stat) begin
            missing_parity_flag <= 1'b0;
        end
    end

    // ---------------- register read port ----------------
    // the host keeps the status two value: reading it clears fields
    wire rx_status_pkg::reg_byte_t fifo_stat_value = {1'b0,
        underflow_flag, overflow_flag, incomplete_flag,
        last_byte_bit_count, missing_parity_flag};
    wire rx_status_pkg::reg_byte_t read_value =
        rd_err_reg ? error_wakeup_irq_flags
        : rd_fifo_fill ? {1'b0, fifo_count}
        : rd_fifo_stat ? fifo_stat_value
        : rd_collision ? collision_position
        : `RESET_BYTE;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_data <= `RESET_BYTE;
            rd_valid <= 1'b0;
        end else begin
            rd_data <= rd_strobe ? read_value : `RESET_BYTE;
            rd_valid <= rd_strobe;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_crc_set;
        crc_error && !set_default |=> error_wakeup_irq_flags[`BIT_CRC];
    endproperty
    a_crc_set: assert property (p_crc_set)
        else $error("crc error flag not set");

    property p_soft_frame;
        last_byte_done && last_byte_no_parity && !set_default |=>
            error_wakeup_irq_flags[`BIT_SOFT_FRAME] && missing_parity_flag;
    endproperty
    a_soft_frame: assert property (p_soft_frame)
        else $error("missing parity not reported as framing error");

    property p_hard_frame;
        hard_framing_error && !set_default |=>
            error_wakeup_irq_flags[`BIT_HARD_FRAME];
    endproperty
    a_hard_frame: assert property (p_hard_frame)
        else $error("hard framing flag not set");

    property p_wake_timer;
        wake_timer_timeout && !wake_timer_irq_every && !set_default
            && !error_wakeup_irq_flags[`BIT_WAKE_TIMER] |=>
            !error_wakeup_irq_flags[`BIT_WAKE_TIMER];
    endproperty
    a_wake_timer: assert property (p_wake_timer)
        else $error("wake timer flag set with option off");

    property p_wake_meas;
        amp_wake && phase_wake && cap_wake && !set_default |=>
            error_wakeup_irq_flags[2:0] == 3'h7;
    endproperty
    a_wake_meas: assert property (p_wake_meas)
        else $error("measurement wake flags not set");

    property p_default;
        set_default |=> error_wakeup_irq_flags == `RESET_BYTE
            && fifo_count == `FIFO_EMPTY && !err_pending
            && collision_position == `RESET_BYTE;
    endproperty
    a_default: assert property (p_default)
        else $error("set default left a register non zero");

    property p_main_clear;
        main_irq_read && !any_flag_set && !set_default |=>
            error_wakeup_irq_flags == `RESET_BYTE;
    endproperty
    a_main_clear: assert property (p_main_clear)
        else $error("main read did not clear error flags");

    // a set-default one cycle on also drops the pending bit legally
    property p_pending;
        any_flag_set && !set_default |=> err_pending
            ##1 (err_pending || $past(rd_err_reg)
            || $past(set_default));
    endproperty
    a_pending: assert property (p_pending)
        else $error("pending bit lost before error register read");

    property p_fill_read;
        rd_fifo_fill |=> rd_valid && rd_data == {1'b0, $past(fifo_count)};
    endproperty
    a_fill_read: assert property (p_fill_read)
        else $error("fifo count read back wrong");

    property p_empty;
        fifo_empty && !set_default |=> fifo_count == `FIFO_EMPTY
            && !incomplete_flag && last_byte_bit_count == 3'h0;
    endproperty
    a_empty: assert property (p_empty)
        else $error("empty fifo shows last byte fields");

    property p_stat_clear;
        rd_fifo_stat && !last_byte_done |=> !incomplete_flag
            && !missing_parity_flag && last_byte_bit_count == 3'h0;
    endproperty
    a_stat_clear: assert property (p_stat_clear)
        else $error("status two read did not clear last byte fields");

    property p_underflow;
        fifo_underflow && !set_default |=> underflow_flag
            ##1 (underflow_flag || $past(rx_start) || $past(set_default));
    endproperty
    a_underflow: assert property (p_underflow)
        else $error("underflow flag not held");

    c_err_then_main: cover property (crc_error ##[1:8] main_irq_read);
    c_partial_read: cover property (last_byte_done && last_byte_partial
        ##[1:8] rd_fifo_stat);
    c_wake: cover property (wake_timer_flag_set ##1 err_pending);
endmodule : rx_error_fifo_status_regs
`default_nettype wire

// ---- host_reader.sv ----
// Purpose: host model reading the receive status registers
// Assumes: requests launched on falling edges, answer one cycle later
// Notes:   keeps fifo status two, since reading it clears fields
`timescale 1ns/1ns
`default_nettype none
module host_reader (
    input wire logic clock,
    input wire logic rd_valid,
    input wire rx_status_pkg::reg_byte_t rd_data,
    output logic rd_strobe,
    output rx_status_pkg::reg_addr_t rd_addr,
    output logic main_irq_read
);
    rx_status_pkg::reg_byte_t saved_status;
    initial begin
        rd_strobe = 1'b0;
        rd_addr = 6'h3f;
        main_irq_read = 1'b0;
        saved_status = 8'h00;
    end
    task automatic read_reg(input rx_status_pkg::reg_addr_t a,
                            output rx_status_pkg::reg_byte_t d);
        @(negedge clock);
        rd_strobe = 1'b1;
        rd_addr = a;
        @(negedge clock);
        d = (rd_valid === 1'b1) ? rd_data : 8'hxx;
        rd_strobe = 1'b0;
        // address no longer qualified, so never leave it looking valid
        rd_addr = ~a;
    endtask : read_reg
    task automatic main_read();
        @(negedge clock);
        main_irq_read = 1'b1;
        @(negedge clock);
        main_irq_read = 1'b0;
    endtask : main_read
    task automatic read_fifo_status(output rx_status_pkg::reg_byte_t f,
                                    output rx_status_pkg::reg_byte_t s);
        read_reg(6'h1a, f);
        read_reg(6'h1b, s);
        saved_status = s;
    endtask : read_fifo_status
endmodule : host_reader
`default_nettype wire

// ---- testbench.sv ----
// Purpose: self-checking bench of the receive status register group
// Assumes: inputs change on falling edges, one-cycle event pulses
// Notes:   reads go through the host model's tasks
`timescale 1ns/1ns
`default_nettype none
`include "rx_status_defs.svh"
module testbench;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic set_default = 1'b0;
    logic [7:0] ev = 8'h00;
    logic wt_every = 1'b1;
    logic rx_start = 1'b0;
    rx_status_pkg::fifo_fill_t fifo_level = 7'h00;
    logic unf = 1'b0;
    logic ovr = 1'b0;
    logic lb_done = 1'b0;
    logic lb_part = 1'b0;
    rx_status_pkg::bit_count_t lb_bits = 3'h0;
    logic lb_np = 1'b0;
    logic col = 1'b0;
    logic col_anti = 1'b0;
    rx_status_pkg::byte_count_t col_byte = 4'h0;
    rx_status_pkg::bit_count_t col_bit = 3'h0;
    logic col_par = 1'b0;
    wire logic rd_strobe;
    wire logic rd_valid;
    wire logic main_irq_read;
    wire logic err_pending;
    wire rx_status_pkg::reg_addr_t rd_addr;
    wire rx_status_pkg::reg_byte_t rd_data;
    rx_status_pkg::reg_byte_t d;
    rx_status_pkg::reg_byte_t f;
    rx_status_pkg::fifo_fill_t lv [4] = '{7'h00, 7'h01, 7'h5f, 7'h60};
    int err_count = 0;
    int checks = 0;
    int cycles = 0;

    always #2 clock = ~clock;

    rx_error_fifo_status_regs i_rx_error_fifo_status_regs (
        .clock(clock), .nrst(nrst), .set_default(set_default),
        .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_valid(rd_valid), .main_irq_read(main_irq_read),
        .err_pending(err_pending), .crc_error(ev[7]),
        .parity_error(ev[6]), .soft_framing_error(ev[5]),
        .hard_framing_error(ev[4]), .wake_timer_timeout(ev[3]),
        .wake_timer_irq_every(wt_every), .amp_wake(ev[2]),
        .phase_wake(ev[1]), .cap_wake(ev[0]), .rx_start(rx_start),
        .fifo_level(fifo_level), .fifo_underflow(unf),
        .fifo_overflow(ovr), .last_byte_done(lb_done),
        .last_byte_partial(lb_part), .last_byte_bits(lb_bits),
        .last_byte_no_parity(lb_np), .collision(col),
        .collision_in_anticoll(col_anti), .collision_byte(col_byte),
        .collision_bit(col_bit), .collision_on_parity(col_par)
    );
    host_reader i_host_reader (
        .clock(clock), .rd_valid(rd_valid), .rd_data(rd_data),
        .rd_strobe(rd_strobe), .rd_addr(rd_addr),
        .main_irq_read(main_irq_read)
    );

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string name,
                         input rx_status_pkg::reg_byte_t seen,
                         input rx_status_pkg::reg_byte_t exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic expect_reg(input rx_status_pkg::reg_addr_t a,
                              input rx_status_pkg::reg_byte_t exp,
                              input string name);
        rx_status_pkg::reg_byte_t v;
        i_host_reader.read_reg(a, v);
        check(name, v, exp);
    endtask : expect_reg

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask : idle

    task automatic pulse_ev(input logic [7:0] m);
        @(negedge clock);
        ev = m;
        @(negedge clock);
        ev = 8'h00;
    endtask : pulse_ev

    task automatic last_byte(input logic p, input logic [2:0] b,
                             input logic np);
        @(negedge clock);
        lb_done = 1'b1;
        lb_part = p;
        lb_bits = b;
        lb_np = np;
        @(negedge clock);
        lb_done = 1'b0;
    endtask : last_byte

    task automatic collide(input logic an, input logic [3:0] by,
                           input logic [2:0] bi, input logic pa);
        @(negedge clock);
        col = 1'b1;
        col_anti = an;
        col_byte = by;
        col_bit = bi;
        col_par = pa;
        @(negedge clock);
        col = 1'b0;
        idle(2);
    endtask : collide

    task automatic rx_begin();
        @(negedge clock);
        rx_start = 1'b1;
        @(negedge clock);
        rx_start = 1'b0;
    endtask : rx_begin

    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        idle(4);
        nrst = 1'b1;
        for (int a = 8'h19; a <= 8'h1d; a++) begin
            expect_reg(a[5:0], `RESET_BYTE, "after reset");
        end
        for (int b = 0; b < 8; b++) begin
            pulse_ev(8'h01 << b);
            idle(1);
            check("pending", {7'h00, err_pending}, 8'h01);
            expect_reg(`ADDR_ERR_WAKE, 8'h01 << b, "flag");
            expect_reg(`ADDR_ERR_WAKE, 8'h01 << b, "reread");
            idle(1);
            check("pending clr", {7'h00, err_pending}, 8'h00);
            i_host_reader.main_read();
            expect_reg(`ADDR_ERR_WAKE, 8'h00, "main clr");
        end
        wt_every = 1'b0;
        pulse_ev(8'h08);
        expect_reg(`ADDR_ERR_WAKE, 8'h00, "timer off");
        check("timer off pend", {7'h00, err_pending}, 8'h00);
        wt_every = 1'b1;
        foreach (lv[i]) begin
            @(negedge clock);
            fifo_level = lv[i];
            idle(2);
            expect_reg(`ADDR_FIFO_FILL, {1'b0, lv[i]}, "fill");
        end
        fifo_level = 7'h05;
        @(negedge clock);
        unf = 1'b1;
        @(negedge clock);
        unf = 1'b0;
        expect_reg(`ADDR_FIFO_STAT, 8'h40, "underflow");
        @(negedge clock);
        ovr = 1'b1;
        @(negedge clock);
        ovr = 1'b0;
        expect_reg(`ADDR_FIFO_STAT, 8'h60, "overflow");
        rx_begin();
        expect_reg(`ADDR_FIFO_STAT, 8'h00, "rx start");
        last_byte(1'b1, 3'h5, 1'b1);
        i_host_reader.read_fifo_status(f, d);
        check("fill lb", f, 8'h05);
        check("status lb", d, 8'h1b);
        check("saved lb", i_host_reader.saved_status, 8'h1b);
        expect_reg(`ADDR_ERR_WAKE, 8'h20, "np framing");
        expect_reg(`ADDR_FIFO_STAT, 8'h00, "lb cleared");
        i_host_reader.main_read();
        @(negedge clock);
        fifo_level = 7'h00;
        idle(2);
        last_byte(1'b1, 3'h3, 1'b1);
        expect_reg(`ADDR_FIFO_STAT, 8'h01, "empty lb");
        expect_reg(`ADDR_FIFO_FILL, 8'h00, "empty fill");
        expect_reg(`ADDR_FIFO_STAT, 8'h00, "np cleared");
        i_host_reader.main_read();
        rx_begin();
        collide(1'b1, 4'h3, 3'h5, 1'b1);
        expect_reg(`ADDR_COLLISION, 8'h3b, "collision");
        expect_reg(`ADDR_ERR_WAKE, 8'h40, "first par col");
        i_host_reader.main_read();
        collide(1'b0, 4'h7, 3'h2, 1'b0);
        expect_reg(`ADDR_COLLISION, 8'h3b, "long frame");
        collide(1'b1, 4'h1, 3'h2, 1'b1);
        expect_reg(`ADDR_COLLISION, 8'h15, "second col");
        expect_reg(`ADDR_ERR_WAKE, 8'h00, "later par col");
        // level must be empty first, the count tracks it continuously
        pulse_ev(8'hff);
        @(negedge clock);
        unf = 1'b1;
        @(negedge clock);
        unf = 1'b0;
        set_default = 1'b1;
        @(negedge clock);
        set_default = 1'b0;
        check("pending dflt", {7'h00, err_pending}, 8'h00);
        for (int a = 8'h19; a <= 8'h1c; a++) begin
            expect_reg(a[5:0], `RESET_BYTE, "set default");
        end
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
